/* File: src/tst_thermostat.sv */
// thermostat controller top: apb registers, i2c target, conversion timer
// assumes the converter answers conv_start_o with one conv_done_i pulse,
// data valid with it; scl and sda arrive unsynchronised from the pins
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - result held as 11-bit two's complement, 0.125 degree
// - three pins pick address, eight devices share
// - bus access never disturbs conversions or updates
// - next read after update returns new value
// - reset: converting, comparator mode, 80 and 75
// - alarm has comparator and interrupt modes
// - alarm active level selectable high or low
// - alarm needs programmable consecutive fault count
// - alarm goes active above the threshold
// - normal mode converts repeatedly, shutdown stops
// - i2c 20 Hz to 400 kHz, timeout frees bus
// - config and result registers readable by controller
// - two writable set-point registers
// - new conversion every 100 ms, load at end
// - config bit 0 selects shutdown, result kept
// - 9-bit set points, compare upper nine bits
// - comparator alarm hysteresis; reads and shutdown keep it
module tst_thermostat #(
   parameter int unsigned CONV_PERIOD = tst_pkg::CONV_PERIOD_CYC,
   parameter int unsigned BUS_TIMEOUT = tst_pkg::BUS_TIMEOUT_CYC,
   parameter logic [3:0] ADDR_HI = 4'h4
) (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   output logic irq_o,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic addr_select_bit_0_i,
   input wire logic addr_select_bit_1_i,
   input wire logic addr_select_bit_2_i,
   output logic overheat_alarm_output_o,
   output logic overheat_alarm_output_oe_o,
   output logic conv_start_o,
   input wire logic conv_done_i,
   input wire logic [10:0] conv_data_i
);

   localparam int CW = $clog2(CONV_PERIOD + 1);
   localparam int TW = $clog2(BUS_TIMEOUT + 1);

   if (CONV_PERIOD < 2) begin : g_chk_conv
      $error("CONV_PERIOD must be at least 2");
   end
   if (BUS_TIMEOUT < 2) begin : g_chk_tout
      $error("BUS_TIMEOUT must be at least 2");
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers

   logic [10:0] temp_q;
   logic [4:0] conf_q;
   logic [8:0] thyst_q;
   logic [8:0] tos_q;
   logic [3:0] stat_q;
   logic [3:0] stat_d;
   logic [3:0] mask_q;
   logic [CW-1:0] conv_cnt_q;
   logic conv_start_q;
   logic sample_stb_q;
   logic shutdown;

   // apb
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic irq_q;
   logic apb_setup;
   logic apb_done;
   logic apb_wr;
   logic [31:0] rd_mux;
   logic rd_hit;

   // pins
   logic [2:0] scl_sy_q;
   logic [2:0] sda_sy_q;
   logic [2:0] asel_m_q;
   logic [2:0] asel_q;
   logic os_oe_q;

   // i2c target
   tst_pkg::tst_i2c_state_e st_q;
   logic [3:0] bcnt_q;
   logic [7:0] shift_q;
   logic rw_q;
   logic [1:0] ptr_q;
   logic idx_q;
   logic first_q;
   logic nack_q;
   logic sda_oe_q;
   logic [15:0] rdw_q;
   logic we_q;
   logic [1:0] wptr_q;
   logic [15:0] wdat_q;
   logic rdclr_q;
   logic tout_ev_q;
   logic [TW-1:0] tout_q;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic tout_hit;
   logic [15:0] word_sel;
   logic [7:0] next_byte;

   tst_alarm_if al ();

   assign shutdown = conf_q[tst_pkg::CONF_SHUTDOWN];

   ////////////////////////////////////////////////////////////////////////////
   // conversion timing and result

   // shutdown holds the count at zero, so the first conversion starts at once on leaving
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         conv_cnt_q <= '0;
         conv_start_q <= 1'b0;
      end else if (shutdown) begin
         conv_cnt_q <= '0;
         conv_start_q <= 1'b0;
      end else if (conv_cnt_q == '0) begin
         conv_cnt_q <= CW'(CONV_PERIOD - 1);
         conv_start_q <= 1'b1;
      end else begin
         conv_cnt_q <= conv_cnt_q - CW'(1);
         conv_start_q <= 1'b0;
      end
   end

   // a conversion already running in the converter still lands when it ends
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         temp_q <= tst_pkg::TEMP_RESET;
         sample_stb_q <= 1'b0;
      end else begin
         if (conv_done_i) begin
            temp_q <= conv_data_i;
         end
         sample_stb_q <= conv_done_i && !shutdown;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // alarm filter and pin

   assign al.sample_stb = sample_stb_q;
   assign al.sample = temp_q[10:2];
   assign al.tos = tos_q;
   assign al.thyst = thyst_q;
   assign al.int_mode = conf_q[tst_pkg::CONF_INT_MODE];
   assign al.fault_code = conf_q[tst_pkg::CONF_FQ_LO +: 2];
   assign al.clear_stb = rdclr_q;

   tst_alarm u_alarm (
      .clk_i(sys_clk_i),
      .reset_i(reset_i),
      .al(al.alarm)
   );

   // open drain: enable pulls the pin low
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         os_oe_q <= 1'b0;
      end else begin
         os_oe_q <= conf_q[tst_pkg::CONF_POL] ? !al.active : al.active;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb slave, one wait-free access phase

   assign apb_setup = psel_i && !penable_i;
   assign apb_done = psel_i && penable_i && pready_q;
   assign apb_wr = apb_done && pwrite_i;

   always_comb begin
      rd_hit = 1'b1;
      rd_mux = 32'h0000_0000;
      unique case (paddr_i)
         tst_pkg::OFS_TEMP: rd_mux[10:0] = temp_q;
         tst_pkg::OFS_CONF: rd_mux[4:0] = conf_q;
         tst_pkg::OFS_THYST: rd_mux[8:0] = thyst_q;
         tst_pkg::OFS_TOS: rd_mux[8:0] = tos_q;
         tst_pkg::OFS_IRQ_STAT: rd_mux[3:0] = stat_q;
         tst_pkg::OFS_IRQ_MASK: rd_mux[3:0] = mask_q;
         tst_pkg::OFS_STATE: rd_mux[7:0] = {ADDR_HI, asel_q, al.active};
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= apb_setup;
         if (apb_setup) begin
            pslverr_q <= !rd_hit;
            prdata_q <= pwrite_i ? 32'h0000_0000 : rd_mux;
         end
      end
   end

   // i2c writes land after apb writes, so they win a same-cycle clash
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         conf_q <= tst_pkg::CONF_RESET;
         thyst_q <= tst_pkg::THYST_RESET;
         tos_q <= tst_pkg::TOS_RESET;
      end else begin
         if (apb_wr && paddr_i == tst_pkg::OFS_CONF) begin
            conf_q <= pwdata_i[4:0];
         end
         if (apb_wr && paddr_i == tst_pkg::OFS_THYST) begin
            thyst_q <= pwdata_i[8:0];
         end
         if (apb_wr && paddr_i == tst_pkg::OFS_TOS) begin
            tos_q <= pwdata_i[8:0];
         end
         if (we_q) begin
            unique case (wptr_q)
               tst_pkg::PTR_CONF: conf_q <= wdat_q[12:8];
               tst_pkg::PTR_THYST: thyst_q <= wdat_q[15:7];
               tst_pkg::PTR_TOS: tos_q <= wdat_q[15:7];
               tst_pkg::PTR_TEMP: ;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         mask_q <= tst_pkg::MASK_RESET;
      end else if (apb_wr && paddr_i == tst_pkg::OFS_IRQ_MASK) begin
         mask_q <= pwdata_i[3:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt status: read clears, a new event in that cycle survives

   // only bits captured at the setup edge are cleared, so an event in between survives
   always_comb begin
      stat_d = stat_q;
      if (apb_done && !pwrite_i && paddr_i == tst_pkg::OFS_IRQ_STAT) begin
         stat_d = stat_q & ~prdata_q[3:0];
      end
      stat_d[tst_pkg::IRQ_CONV] = stat_d[tst_pkg::IRQ_CONV] | sample_stb_q;
      stat_d[tst_pkg::IRQ_ALARM_ON] = stat_d[tst_pkg::IRQ_ALARM_ON] | al.assert_stb;
      stat_d[tst_pkg::IRQ_ALARM_OFF] = stat_d[tst_pkg::IRQ_ALARM_OFF] | al.release_stb;
      stat_d[tst_pkg::IRQ_TIMEOUT] = stat_d[tst_pkg::IRQ_TIMEOUT] | tout_ev_q;
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         stat_q <= 4'h0;
         irq_q <= 1'b0;
      end else begin
         stat_q <= stat_d;
         irq_q <= |(stat_d & mask_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers; stage 0 feeds stage 1 only

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         scl_sy_q <= 3'h7;
         sda_sy_q <= 3'h7;
         asel_m_q <= 3'h0;
         asel_q <= 3'h0;
      end else begin
         scl_sy_q <= {scl_sy_q[1:0], scl_i};
         sda_sy_q <= {sda_sy_q[1:0], sda_i};
         asel_m_q <= {addr_select_bit_2_i, addr_select_bit_1_i, addr_select_bit_0_i};
         asel_q <= asel_m_q;
      end
   end

   // 50 MHz gives over 60 samples per 400 kHz scl phase, so edges are clean
   assign scl_rise = scl_sy_q[1] && !scl_sy_q[2];
   assign scl_fall = !scl_sy_q[1] && scl_sy_q[2];
   assign bus_start = scl_sy_q[1] && scl_sy_q[2] && sda_sy_q[2] && !sda_sy_q[1];
   assign bus_stop = scl_sy_q[1] && scl_sy_q[2] && !sda_sy_q[2] && sda_sy_q[1];
   assign tout_hit = tout_q == TW'(BUS_TIMEOUT);

   ////////////////////////////////////////////////////////////////////////////
   // i2c target

   // read word is frozen at the address ack, so both bytes of a read come from one result
   always_comb begin
      unique case (ptr_q)
         tst_pkg::PTR_TEMP: word_sel = {temp_q, 5'h00};
         tst_pkg::PTR_CONF: word_sel = {3'h0, conf_q, 3'h0, conf_q};
         tst_pkg::PTR_THYST: word_sel = {thyst_q, 7'h00};
         tst_pkg::PTR_TOS: word_sel = {tos_q, 7'h00};
      endcase
      next_byte = idx_q ? rdw_q[15:8] : rdw_q[7:0];
   end

   // an idle bus or any scl edge restarts the stuck-bus timer
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         tout_q <= '0;
      end else if (st_q == tst_pkg::I2C_IDLE || scl_rise || scl_fall || tout_hit) begin
         tout_q <= '0;
      end else begin
         tout_q <= tout_q + TW'(1);
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         st_q <= tst_pkg::I2C_IDLE;
         bcnt_q <= 4'h0;
         shift_q <= 8'h00;
         rw_q <= 1'b0;
         ptr_q <= tst_pkg::PTR_TEMP;
         idx_q <= 1'b0;
         first_q <= 1'b0;
         nack_q <= 1'b0;
         sda_oe_q <= 1'b0;
         rdw_q <= 16'h0000;
         we_q <= 1'b0;
         wptr_q <= tst_pkg::PTR_TEMP;
         wdat_q <= 16'h0000;
         rdclr_q <= 1'b0;
         tout_ev_q <= 1'b0;
      end else begin
         we_q <= 1'b0;
         rdclr_q <= 1'b0;
         tout_ev_q <= 1'b0;
         if (tout_hit) begin
            st_q <= tst_pkg::I2C_IDLE;
            sda_oe_q <= 1'b0;
            tout_ev_q <= 1'b1;
         end else if (bus_start) begin
            st_q <= tst_pkg::I2C_ADDR;
            bcnt_q <= 4'h0;
            sda_oe_q <= 1'b0;
         end else if (bus_stop) begin
            st_q <= tst_pkg::I2C_IDLE;
            sda_oe_q <= 1'b0;
         end else if (scl_rise) begin
            bcnt_q <= bcnt_q + 4'h1;
            if (st_q == tst_pkg::I2C_ADDR || st_q == tst_pkg::I2C_WR) begin
               shift_q <= {shift_q[6:0], sda_sy_q[1]};
            end
            if (st_q == tst_pkg::I2C_RACK) begin
               nack_q <= sda_sy_q[1];
            end
         end else if (scl_fall) begin
            unique case (st_q)
               tst_pkg::I2C_IDLE: ;
               tst_pkg::I2C_ADDR: begin
                  if (bcnt_q == 4'h8) begin
                     if (shift_q[7:1] == {ADDR_HI, asel_q}) begin
                        rw_q <= shift_q[0];
                        sda_oe_q <= 1'b1;
                        st_q <= tst_pkg::I2C_AACK;
                        idx_q <= 1'b0;
                        first_q <= 1'b1;
                        rdw_q <= word_sel;
                        rdclr_q <= shift_q[0];
                     end else begin
                        st_q <= tst_pkg::I2C_IDLE;
                     end
                  end
               end
               tst_pkg::I2C_AACK: begin
                  if (bcnt_q == 4'h9) begin
                     bcnt_q <= 4'h0;
                     if (rw_q) begin
                        st_q <= tst_pkg::I2C_RD;
                        shift_q <= rdw_q[15:8];
                        sda_oe_q <= !rdw_q[15];
                        idx_q <= 1'b1;
                     end else begin
                        st_q <= tst_pkg::I2C_WR;
                        sda_oe_q <= 1'b0;
                     end
                  end
               end
               tst_pkg::I2C_WR: begin
                  if (bcnt_q == 4'h8) begin
                     sda_oe_q <= 1'b1;
                     st_q <= tst_pkg::I2C_WACK;
                     if (first_q) begin
                        ptr_q <= shift_q[1:0];
                        first_q <= 1'b0;
                     end else if (!idx_q) begin
                        wdat_q[15:8] <= shift_q;
                        wptr_q <= ptr_q;
                        we_q <= ptr_q == tst_pkg::PTR_CONF;
                        idx_q <= 1'b1;
                     end else begin
                        wdat_q[7:0] <= shift_q;
                        wptr_q <= ptr_q;
                        we_q <= ptr_q != tst_pkg::PTR_CONF;
                        idx_q <= 1'b0;
                     end
                  end
               end
               tst_pkg::I2C_WACK: begin
                  if (bcnt_q == 4'h9) begin
                     bcnt_q <= 4'h0;
                     sda_oe_q <= 1'b0;
                     st_q <= tst_pkg::I2C_WR;
                  end
               end
               tst_pkg::I2C_RD: begin
                  if (bcnt_q == 4'h8) begin
                     sda_oe_q <= 1'b0;
                     st_q <= tst_pkg::I2C_RACK;
                  end else begin
                     shift_q <= {shift_q[6:0], 1'b0};
                     sda_oe_q <= !shift_q[6];
                  end
               end
               tst_pkg::I2C_RACK: begin
                  if (bcnt_q == 4'h9) begin
                     bcnt_q <= 4'h0;
                     if (nack_q) begin
                        st_q <= tst_pkg::I2C_IDLE;
                     end else begin
                        st_q <= tst_pkg::I2C_RD;
                        shift_q <= next_byte;
                        sda_oe_q <= !next_byte[7];
                        idx_q <= !idx_q;
                     end
                  end
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         sda_o <= 1'b0;
         overheat_alarm_output_o <= 1'b0;
      end else begin
         sda_o <= 1'b0;
         overheat_alarm_output_o <= 1'b0;
      end
   end

   assign prdata_o = prdata_q;
   assign pready_o = pready_q;
   assign pslverr_o = pslverr_q;
   assign irq_o = irq_q;
   assign sda_oe_o = sda_oe_q;
   assign overheat_alarm_output_oe_o = os_oe_q;
   assign conv_start_o = conv_start_q;

endmodule

/* File: src/tst_pkg.sv */
// constants, state codes and helpers shared by the thermostat controller
// assumes a 50 MHz system clock; long counts are overridable at the top level
package tst_pkg;

   localparam int unsigned SYS_CLK_HZ = 50_000_000;
   localparam int unsigned CONV_PERIOD_MS = 100;
   localparam int unsigned CONV_PERIOD_CYC = CONV_PERIOD_MS * (SYS_CLK_HZ / 1000);
   localparam int unsigned BUS_TIMEOUT_MS = 30;
   localparam int unsigned BUS_TIMEOUT_CYC = BUS_TIMEOUT_MS * (SYS_CLK_HZ / 1000);

   localparam int TEMP_W = 11;
   localparam int SET_W = 9;
   localparam int CONF_W = 5;
   localparam int IRQ_W = 4;

   // set points in half degree steps: 80 and 75 degrees
   localparam logic [8:0] TOS_RESET = 9'h0a0;
   localparam logic [8:0] THYST_RESET = 9'h096;
   localparam logic [4:0] CONF_RESET = 5'h00;
   localparam logic [3:0] MASK_RESET = 4'h0;
   localparam logic [10:0] TEMP_RESET = 11'h000;

   localparam int CONF_SHUTDOWN = 0;
   localparam int CONF_INT_MODE = 1;
   localparam int CONF_POL = 2;
   localparam int CONF_FQ_LO = 3;

   localparam int IRQ_CONV = 0;
   localparam int IRQ_ALARM_ON = 1;
   localparam int IRQ_ALARM_OFF = 2;
   localparam int IRQ_TIMEOUT = 3;

   localparam logic [7:0] OFS_TEMP = 8'h00;
   localparam logic [7:0] OFS_CONF = 8'h04;
   localparam logic [7:0] OFS_THYST = 8'h08;
   localparam logic [7:0] OFS_TOS = 8'h0c;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
   localparam logic [7:0] OFS_STATE = 8'h18;

   localparam logic [1:0] PTR_TEMP = 2'h0;
   localparam logic [1:0] PTR_CONF = 2'h1;
   localparam logic [1:0] PTR_THYST = 2'h2;
   localparam logic [1:0] PTR_TOS = 2'h3;

   typedef enum logic [6:0] {
      I2C_IDLE = 7'h01,
      I2C_ADDR = 7'h02,
      I2C_AACK = 7'h04,
      I2C_WR = 7'h08,
      I2C_WACK = 7'h10,
      I2C_RD = 7'h20,
      I2C_RACK = 7'h40
   } tst_i2c_state_e;

   function automatic logic [2:0] fault_limit(input logic [1:0] code);
      fault_limit = {1'b0, code} + 3'h1;
   endfunction

   function automatic logic set_gt(input logic [8:0] a, input logic [8:0] b);
      set_gt = $signed(a) > $signed(b);
   endfunction

endpackage

/* File: src/tst_alarm_if.sv */
// signals between the register side and the alarm filter
// assumes both ends run on the system clock
`timescale 1ns/10ps
interface tst_alarm_if;
   logic sample_stb;
   logic [8:0] sample;
   logic [8:0] tos;
   logic [8:0] thyst;
   logic int_mode;
   logic clear_stb;
   logic [1:0] fault_code;
   logic active;
   logic assert_stb;
   logic release_stb;
   modport ctrl (output sample_stb, sample, tos, thyst, int_mode, clear_stb, fault_code,
                 input active, assert_stb, release_stb);
   modport alarm (input sample_stb, sample, tos, thyst, int_mode, clear_stb, fault_code,
                  output active, assert_stb, release_stb);
endinterface

/* File: src/tst_alarm.sv */
// alarm filter: compares each sample with the set points and counts faults
// assumes sample_stb pulses once per finished conversion in normal mode
`timescale 1ns/10ps
module tst_alarm (
   input wire logic clk_i,
   input wire logic reset_i,
   tst_alarm_if.alarm al
);

   logic active_q;
   logic active_d;
   logic armed_hot_q;
   logic [2:0] run_q;
   logic assert_q;
   logic release_q;
   logic look_hot;
   logic cond;
   logic fire;

   always_comb begin
      // comparator mode hunts for the opposite of its present state
      look_hot = al.int_mode ? armed_hot_q : !active_q;
      cond = look_hot ? tst_pkg::set_gt(al.sample, al.tos)
                      : tst_pkg::set_gt(al.thyst, al.sample);
      fire = al.sample_stb && cond
             && (3'(run_q + 3'h1) >= tst_pkg::fault_limit(al.fault_code));
      active_d = active_q;
      if (fire) begin
         active_d = al.int_mode ? 1'b1 : !active_q;
      end else if (al.int_mode && al.clear_stb) begin
         // an i2c read releases the interrupt-mode alarm; a new fault wins
         active_d = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         run_q <= 3'h0;
      end else if (al.sample_stb) begin
         run_q <= (fire || !cond) ? 3'h0 : 3'(run_q + 3'h1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         active_q <= 1'b0;
         armed_hot_q <= 1'b1;
         assert_q <= 1'b0;
         release_q <= 1'b0;
      end else begin
         active_q <= active_d;
         if (!al.int_mode) begin
            armed_hot_q <= 1'b1;
         end else if (fire) begin
            armed_hot_q <= !armed_hot_q;
         end
         assert_q <= !active_q && active_d;
         release_q <= active_q && !active_d;
      end
   end

   assign al.active = active_q;
   assign al.assert_stb = assert_q;
   assign al.release_stb = release_q;

endmodule

/* File: test/tst_asserts.sv */
// port checker for the thermostat controller top
// assumes the apb master and the converter share sys_clk_i
`timescale 1ns/10ps
module tst_asserts (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic sda_o,
   input wire logic overheat_alarm_output_o,
   input wire logic conv_start_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   AST_RDY: assert property (psel_i && !penable_i |=> pready_o)
      else $error("no ready after setup");
   AST_RDY_ONE: assert property (pready_o |=> !pready_o)
      else $error("ready held too long");
   AST_UNMAP: assert property (pready_o && paddr_i == 8'h1c |-> pslverr_o && prdata_o == 32'h0)
      else $error("unmapped access not refused");
   AST_TEMP_W: assert property (pready_o && !pwrite_i && paddr_i == 8'h00
      |-> prdata_o[31:11] == 21'h0) else $error("result wider than 11 bits");
   AST_WR_ZERO: assert property (pready_o && pwrite_i |-> prdata_o == 32'h0)
      else $error("read data on a write");
   AST_SDA: assert property (!sda_o)
      else $error("sda driven high");
   AST_ALARM_PIN: assert property (!overheat_alarm_output_o)
      else $error("alarm pin driven high");
   AST_START: assert property (conv_start_o |=> !conv_start_o [*8])
      else $error("starts too close");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind tst_thermostat tst_asserts chk_u (.sys_clk_i, .reset_i, .psel_i, .penable_i, .pwrite_i,
   .paddr_i, .prdata_o, .pready_o, .pslverr_o, .sda_o, .overheat_alarm_output_o, .conv_start_o);

/* File: test/tst_i2c_host.sv */
// i2c controller model for the thermostat target
// assumes a pull-up on sda, merged with the target's pull-down by the bench
`timescale 1ns/10ps
module tst_i2c_host (
   output logic scl_o,
   output logic sda_low_o,
   input wire logic sda_i
);
   // scl rests high between frames; a bit takes 160 ns
   initial {scl_o, sda_low_o} = 2'b10;
   // callers return on a clock edge; the odd first delay keeps pins off that edge
   task automatic start();
      #25 sda_low_o = 1'b1;
      #40 scl_o = 1'b0;
   endtask
   task automatic stop();
      #40 sda_low_o = 1'b1;
      #40 scl_o = 1'b1;
      #40 sda_low_o = 1'b0;
   endtask
   // byte then ack bit; r[0] low means acknowledged
   task automatic xfer(input logic [7:0] w, input logic m, output logic [8:0] r);
      for (int i = 8; i >= 0; i--) begin
         #40 sda_low_o = !(i > 0 ? w[i-1] : m);
         #40 scl_o = 1'b1;
         #40 r[i] = sda_i;
         #40 scl_o = 1'b0;
      end
   endtask
endmodule

/* File: test/tst_thermostat_tb_top.sv */
// self-checking bench for the thermostat controller
// assumes 200 cycle conversions and address straps 3'b101
`timescale 1ns/10ps
module tst_thermostat_tb_top;
   logic sys_clk_i = 1'b0, reset_i = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, cd = 1'b0;
   logic rdy, err, irq, so, soe, ao, aoe, cs, scl, ml;
   logic [7:0] pa = 8'h00;
   logic [31:0] pwd = 32'h0, prd, rv;
   logic [10:0] t = 11'h000, cdat = 11'h000;
   logic [8:0] r;
   int errors = 0, check_count = 0, starts = 0;
   wire sda = !(soe || ml);
   tst_thermostat #(.CONV_PERIOD(200)) dut_u (.sys_clk_i, .reset_i, .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd),
      .pready_o(rdy), .pslverr_o(err), .irq_o(irq), .scl_i(scl), .sda_i(sda), .sda_o(so),
      .sda_oe_o(soe), .addr_select_bit_0_i(1'b1), .addr_select_bit_1_i(1'b0),
      .addr_select_bit_2_i(1'b1), .overheat_alarm_output_o(ao),
      .overheat_alarm_output_oe_o(aoe), .conv_start_o(cs), .conv_done_i(cd),
      .conv_data_i(cdat));
   tst_i2c_host host_u (.scl_o(scl), .sda_low_o(ml), .sda_i(sda));
   always #10 sys_clk_i = ~sys_clk_i;
   // converter stub: answers each start one cycle later with t
   always @(posedge sys_clk_i) begin
      cd <= cs;
      cdat <= t;
      starts <= starts + int'(cs === 1'b1);
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) $display("BAD %0t got %h want %h", $time, g, e);
      errors += int'(g !== e);
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge sys_clk_i);
      {psel, pwr, pa, pwd} <= {1'b1, w, a, d};
      @(posedge sys_clk_i);
      pen <= 1'b1;
      do @(posedge sys_clk_i); while (rdy !== 1'b1 && ++n < 20);
      if (n >= 20) begin
         errors++;
         $display("BAD %0t no pready", $time);
      end
      rv = prd;
      {psel, pen} <= 2'b00;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rv, e);
   endtask
   // lines up on a start so later reads cannot race the next sample
   task automatic conv();
      int n = 0;
      do @(posedge sys_clk_i); while (cs !== 1'b1 && ++n < 300);
      if (n >= 300) begin
         errors++;
         $display("BAD %0t no conversion start", $time);
      end
      repeat (5) @(posedge sys_clk_i);
   endtask
   task automatic t_basic();
      rd(8'h04, 32'h0);
      rd(8'h08, 32'h096);
      rd(8'h0c, 32'h0a0);
      rd(8'h1c, 32'h0);
      chk(err, 1'b1);
      chk(irq, 1'b0);
      t <= 11'h7f9;
      apb(1'b1, 8'h14, 32'h1);
      conv();
      chk(irq, 1'b1);
      rd(8'h00, 32'h7f9);
      rd(8'h10, 32'h1);
      repeat (2) @(posedge sys_clk_i);
      chk(irq, 1'b0);
      $display("basic test done");
   endtask
   task automatic t_alarm();
      logic [10:0] tv[4] = '{11'h283, 11'h288, 11'h270, 11'h230};
      logic [3:0] ev = 4'b0110;
      for (int i = 0; i < 4; i++) begin
         t <= tv[i];
         conv();
         chk(aoe, ev[i]);
      end
      apb(1'b1, 8'h04, 32'h4);
      repeat (3) @(posedge sys_clk_i);
      chk(aoe, 1'b1);
      apb(1'b1, 8'h04, 32'h18);
      t <= 11'h288;
      for (int i = 0; i < 4; i++) begin
         conv();
         chk(aoe, i == 3);
      end
      $display("alarm test done");
   endtask
   task automatic t_shut();
      int s;
      apb(1'b1, 8'h04, 32'h1);
      repeat (3) @(posedge sys_clk_i);
      s = starts;
      t <= 11'h100;
      repeat (450) @(posedge sys_clk_i);
      chk(starts, s);
      rd(8'h00, 32'h288);
      chk(aoe, 1'b1);
      apb(1'b1, 8'h04, 32'h0);
      repeat (5) @(posedge sys_clk_i);
      chk(starts, s + 1);
      $display("shutdown test done");
   endtask
   task automatic t_i2c();
      logic [7:0] wb[4] = '{8'h4a, 8'h03, 8'h50, 8'h80};
      apb(1'b1, 8'h04, 32'h2);
      t <= 11'h288;
      conv();
      chk(aoe, 1'b1);
      host_u.start();
      host_u.xfer(8'h4b, 1'b1, r);
      chk(r[0], 1'b0);
      host_u.xfer(8'hff, 1'b1, r);
      chk(r[8:1], 8'h51);
      host_u.stop();
      chk(aoe, 1'b0);
      host_u.start();
      foreach (wb[i]) host_u.xfer(wb[i], 1'b1, r);
      chk(r[0], 1'b0);
      host_u.stop();
      rd(8'h0c, 32'h0a1);
      $display("i2c test done");
   endtask
   task automatic wrap_up();
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      t_basic();
      t_alarm();
      t_shut();
      t_i2c();
      wrap_up();
   end
   initial begin
      #1000000;
      errors++;
      wrap_up();
   end
endmodule
